// File: rtl/clm_action_regs.svh
// register map, field positions, encodings and byte counts of the action decoder
`ifndef CLM_ACTION_REGS_SVH
`define CLM_ACTION_REGS_SVH

// apb register byte offsets
`define REG_CFG_OFS        12'h000
`define REG_STATUS_OFS     12'h004
`define REG_DONE_CNT_OFS   12'h008
`define REG_CLAMP_CNT_OFS  12'h00c

// cfg register: one triple vlan variant bit for each of lookups 0 to 2
`define CFG_TRI_SEL_LSB    0
`define CFG_TRI_SEL_W      3
`define CFG_RESET          3'h0

// status register field positions
`define ST_KEY_LSB         0
`define ST_FTYPE_LSB       8
`define ST_PTR_LSB         16
`define ST_DONE_BIT        24
`define ST_PP_VALID_BIT    25

// next lookup key select codes
`define KEY_DEFAULT        4'h0
`define KEY_LINK           4'h1
`define KEY_SINGLE         4'h2
`define KEY_DOUBLE         4'h3
`define KEY_TRIPLE         4'h4
`define KEY_TRI_VLAN       4'h5
`define KEY_FULL_LINK      4'h6
`define KEY_STANDARD       4'h7
`define KEY_STANDARD_DST   4'h8
`define KEY_FIVE_V4        4'h9
`define KEY_BARE_FIVE_V4   4'hb
`define KEY_USER1          4'hc
`define KEY_USER2          4'hd
`define KEY_USER4          4'he
`define KEY_FINISHED       4'hf

// frame type codes
`define FT_MAC             2'h0
`define FT_CW              2'h1
`define FT_MPLS            2'h2
`define FT_RAW             2'h3

// layer skip select codes
`define SKIP_NONE          2'h0
`define SKIP_LINK          2'h1
`define SKIP_NET_LINK      2'h2

// ip versions
`define IP_VER4            4'h4
`define IP_VER6            4'h6

// byte counts used by the pointer arithmetic
`define MAC_PAIR_BYTES     7'h0c
`define VLAN_TAG_BYTES     7'h04
`define IP6_HDR_BYTES      7'h28
`define STRIP_MAX_BYTES    8'h2a
`define PTR_MAX            8'hff

`endif

// File: rtl/clm_action_pkg.sv
// types shared by the action pointer control block
package clm_action_pkg;
`include "clm_action_regs.svh"

	typedef enum logic [1:0] {
		mac_layer_type    = `FT_MAC,
		control_word_type = `FT_CW,
		mpls_type         = `FT_MPLS,
		raw_data_type     = `FT_RAW
	} frame_type_t;

	typedef enum logic [4:0] {
		default_key,
		link_layer_key,
		single_label_key,
		double_label_key,
		triple_label_key,
		triple_vlan_key,
		triple_vlan_index_key,
		full_link_layer_key,
		standard_key,
		standard_dst_key,
		standard_five_field_v4_key,
		bare_five_field_v4_key,
		user_key_1,
		user_key_2,
		user_key_4,
		lookups_finished,
		reserved_key
	} key_kind_t;

endpackage : clm_action_pkg

// File: rtl/layer_skip_calc.sv
// byte distance of a protocol layer skip from the current frame type
module layer_skip_calc
	import clm_action_pkg::*;
(
	input  wire frame_type_t frame_type_i,
	input  wire logic [1:0]  layer_skip_select_i,
	input  wire logic [1:0]  vlan_cnt_i,
	input  wire logic [3:0]  ip_version_i,
	input  wire logic [3:0]  ipv4_ihl_i,
	output logic      [6:0]  skip_bytes_o
);
	logic [6:0] link_bytes;
	logic [6:0] ip_bytes;
	logic       is_ip;

	// header sizes; ihl counts 4-byte words so options are covered
	always_comb begin
		link_bytes = `MAC_PAIR_BYTES + `VLAN_TAG_BYTES * {5'h00, vlan_cnt_i};
		is_ip      = (ip_version_i == `IP_VER4) || (ip_version_i == `IP_VER6);
		if (ip_version_i == `IP_VER4) begin
			ip_bytes = {1'b0, ipv4_ihl_i, 2'b00};
		end else if (ip_version_i == `IP_VER6) begin
			ip_bytes = `IP6_HDR_BYTES;
		end else begin
			ip_bytes = 7'h00;
		end
	end

	// distance per skip select; reserved code moves nothing
	always_comb begin
		skip_bytes_o = 7'h00;
		case (layer_skip_select_i)
			`SKIP_LINK: begin
				if (frame_type_i == mac_layer_type) begin
					skip_bytes_o = link_bytes;
				end
			end
			`SKIP_NET_LINK: begin
				if (frame_type_i == mac_layer_type) begin
					skip_bytes_o = link_bytes + ip_bytes;
				end else if (frame_type_i == control_word_type && is_ip) begin
					skip_bytes_o = ip_bytes;
				end
			end
			default: begin
				skip_bytes_o = 7'h00;
			end
		endcase
	end

endmodule : layer_skip_calc

// File: rtl/clm_action_pointer_ctrl.sv
// decoder of lookup action fields: key select, pipeline point, frame pointer
module clm_action_pointer_ctrl
	import clm_action_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic             pready_o,
	output logic      [31:0] prdata_o,
	output logic             pslverr_o,
	// frame context
	input  wire logic        frame_start_i,
	input  wire logic [1:0]  lookup_idx_i,
	input  wire frame_type_t frame_type_i,
	input  wire logic [7:0]  frame_ptr_i,
	input  wire logic [1:0]  vlan_cnt_i,
	input  wire logic [3:0]  ip_version_i,
	input  wire logic [3:0]  ipv4_ihl_i,
	// action fields from the lookup result
	input  wire logic        act_valid_i,
	input  wire logic        reduced_layout_i,
	input  wire logic        force_pipeline_point_enable_i,
	input  wire logic [2:0]  reduced_pipeline_point_i,
	input  wire logic [4:0]  pipeline_point_i,
	input  wire logic [3:0]  next_lookup_key_select_i,
	input  wire logic [1:0]  next_ptr_word4_advance_i,
	input  wire logic [4:0]  next_ptr_word2_advance_i,
	input  wire logic [1:0]  layer_skip_select_i,
	input  wire frame_type_t layer_type_after_move_i,
	input  wire logic        strip_to_pointer_i,
	// results toward key generator and rewriter
	output logic             res_valid_o,
	output key_kind_t        next_key_o,
	output logic [7:0]       next_ptr_o,
	output frame_type_t      next_frame_type_o,
	output logic             lookups_disabled_o,
	output logic             pp_valid_o,
	output logic             pp_reduced_o,
	output logic [4:0]       pp_code_o,
	output logic             strip_o,
	output logic [5:0]       strip_bytes_o,
	output logic             strip_clamped_o
);
	logic [`CFG_TRI_SEL_W-1:0] tri_sel_r,   tri_sel_nxt;
	logic [31:0]               prdata_r,    prdata_nxt;
	logic [15:0]               done_cnt_r,  done_cnt_nxt;
	logic [15:0]               clamp_cnt_r, clamp_cnt_nxt;
	logic                      res_valid_r, res_valid_nxt;
	key_kind_t                 key_r,       key_nxt;
	logic [7:0]                ptr_r,       ptr_nxt;
	frame_type_t               ftype_r,     ftype_nxt;
	logic                      done_r,      done_nxt;
	logic                      pp_valid_r,  pp_valid_nxt;
	logic                      pp_red_r,    pp_red_nxt;
	logic [4:0]                pp_code_r,   pp_code_nxt;
	logic                      strip_r,     strip_nxt;
	logic [5:0]                strip_b_r,   strip_b_nxt;
	logic                      clamp_r,     clamp_nxt;

	logic [6:0] skip_bytes;
	logic [6:0] adv_bytes;
	logic [7:0] move_bytes;
	logic [9:0] ptr_sum;
	logic [7:0] ptr_new;
	logic       moved;
	logic       act_take;
	logic       clamp_evt;
	logic       wr_en;
	logic       rd_setup;
	logic       mapped;
	key_kind_t  key_dec;

	// distance of the protocol layer skip
	layer_skip_calc u_skip (
		.frame_type_i        (frame_type_i),
		.layer_skip_select_i (layer_skip_select_i),
		.vlan_cnt_i          (vlan_cnt_i),
		.ip_version_i        (ip_version_i),
		.ipv4_ihl_i          (ipv4_ihl_i),
		.skip_bytes_o        (skip_bytes)
	);

	// pointer arithmetic: layer skip first, then the word advance on top
	always_comb begin
		if (reduced_layout_i) begin
			adv_bytes = {3'h0, next_ptr_word4_advance_i, 2'b00};
		end else begin
			adv_bytes = {1'b0, next_ptr_word2_advance_i, 1'b0};
		end
		move_bytes = {1'b0, skip_bytes} + {1'b0, adv_bytes};
		// frame_ptr_i is already past auto-skipped labels
		ptr_sum = {2'b00, frame_ptr_i} + {2'b00, move_bytes};
		// saturate rather than wrap so a bad entry cannot alias to low bytes
		ptr_new = (ptr_sum > {2'b00, `PTR_MAX}) ? `PTR_MAX : ptr_sum[7:0];
		moved   = (move_bytes != 8'h00);
	end

	// key select decode
	always_comb begin
		key_dec = reserved_key;
		case (next_lookup_key_select_i)
			`KEY_DEFAULT:      key_dec = default_key;
			`KEY_LINK:         key_dec = link_layer_key;
			`KEY_SINGLE:       key_dec = single_label_key;
			`KEY_DOUBLE:       key_dec = double_label_key;
			`KEY_TRIPLE:       key_dec = triple_label_key;
			`KEY_TRI_VLAN: begin
				if (lookup_idx_i < 2'(`CFG_TRI_SEL_W) && tri_sel_r[lookup_idx_i]) begin
					key_dec = triple_vlan_index_key;
				end else begin
					key_dec = triple_vlan_key;
				end
			end
			`KEY_FULL_LINK:    key_dec = full_link_layer_key;
			`KEY_STANDARD:     key_dec = standard_key;
			`KEY_STANDARD_DST: key_dec = standard_dst_key;
			`KEY_FIVE_V4:      key_dec = standard_five_field_v4_key;
			`KEY_BARE_FIVE_V4: key_dec = bare_five_field_v4_key;
			`KEY_USER1:        key_dec = user_key_1;
			`KEY_USER2:        key_dec = user_key_2;
			`KEY_USER4:        key_dec = user_key_4;
			`KEY_FINISHED:     key_dec = lookups_finished;
			default:           key_dec = reserved_key;
		endcase
	end

	// action result; actions after lookups finished are dropped
	always_comb begin
		act_take      = act_valid_i && !(done_r && !frame_start_i);
		res_valid_nxt = act_take;
		key_nxt       = key_r;
		ptr_nxt       = ptr_r;
		ftype_nxt     = ftype_r;
		strip_nxt     = strip_r;
		strip_b_nxt   = strip_b_r;
		clamp_nxt     = clamp_r;
		clamp_evt     = 1'b0;
		if (act_take) begin
			key_nxt = key_dec;
			ptr_nxt = ptr_new;
			ftype_nxt = frame_type_i;
			if (moved || (frame_type_i == raw_data_type
			    && next_lookup_key_select_i != `KEY_DEFAULT)) begin
				ftype_nxt = layer_type_after_move_i;
			end
			// strip length is the updated pointer, capped at rewriter limit
			strip_nxt = strip_to_pointer_i;
			if (ptr_new > `STRIP_MAX_BYTES) begin
				strip_b_nxt = 6'(`STRIP_MAX_BYTES);
				clamp_nxt   = strip_to_pointer_i;
			end else begin
				strip_b_nxt = ptr_new[5:0];
				clamp_nxt   = 1'b0;
			end
			clamp_evt = strip_to_pointer_i && (ptr_new > `STRIP_MAX_BYTES);
		end
	end

	// per-frame state: finished flag and forced pipeline point
	always_comb begin
		done_nxt     = done_r;
		pp_valid_nxt = pp_valid_r;
		pp_red_nxt   = pp_red_r;
		pp_code_nxt  = pp_code_r;
		if (frame_start_i) begin
			done_nxt     = 1'b0;
			pp_valid_nxt = 1'b0;
			pp_red_nxt   = 1'b0;
			pp_code_nxt  = 5'h00;
		end
		if (act_take) begin
			if (next_lookup_key_select_i == `KEY_FINISHED) begin
				done_nxt = 1'b1;
			end
			// forcing replaces whatever point an earlier entry set
			if (force_pipeline_point_enable_i) begin
				pp_valid_nxt = 1'b1;
				pp_red_nxt   = reduced_layout_i;
				if (reduced_layout_i) begin
					pp_code_nxt = {2'b00, reduced_pipeline_point_i};
				end else begin
					pp_code_nxt = pipeline_point_i;
				end
			end
		end
	end

	// apb decode; zero wait states, errors on unmapped offsets
	always_comb begin
		mapped = (paddr_i == `REG_CFG_OFS) || (paddr_i == `REG_STATUS_OFS)
		      || (paddr_i == `REG_DONE_CNT_OFS)
		      || (paddr_i == `REG_CLAMP_CNT_OFS);
		wr_en    = psel_i && penable_i && pwrite_i && mapped;
		rd_setup = psel_i && !penable_i && !pwrite_i;
		tri_sel_nxt = tri_sel_r;
		if (wr_en && paddr_i == `REG_CFG_OFS && pstrb_i[0]) begin
			tri_sel_nxt = pwdata_i[`CFG_TRI_SEL_LSB +: `CFG_TRI_SEL_W];
		end
		prdata_nxt = prdata_r;
		if (rd_setup) begin
			prdata_nxt = 32'h0000_0000;
			case (paddr_i)
				`REG_CFG_OFS: begin
					prdata_nxt[`CFG_TRI_SEL_LSB +: `CFG_TRI_SEL_W] = tri_sel_r;
				end
				`REG_STATUS_OFS: begin
					prdata_nxt[`ST_KEY_LSB +: 5]   = key_r;
					prdata_nxt[`ST_FTYPE_LSB +: 2] = ftype_r;
					prdata_nxt[`ST_PTR_LSB +: 8]   = ptr_r;
					prdata_nxt[`ST_DONE_BIT]       = done_r;
					prdata_nxt[`ST_PP_VALID_BIT]   = pp_valid_r;
				end
				`REG_DONE_CNT_OFS:  prdata_nxt[15:0] = done_cnt_r;
				`REG_CLAMP_CNT_OFS: prdata_nxt[15:0] = clamp_cnt_r;
				default:            prdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// event counters, each cleared by a write to its own offset; an event in the clear cycle counts
	always_comb begin
		done_cnt_nxt  = done_cnt_r;
		clamp_cnt_nxt = clamp_cnt_r;
		if (wr_en && paddr_i == `REG_DONE_CNT_OFS) begin
			done_cnt_nxt = 16'h0000;
		end
		if (wr_en && paddr_i == `REG_CLAMP_CNT_OFS) begin
			clamp_cnt_nxt = 16'h0000;
		end
		if (act_take && next_lookup_key_select_i == `KEY_FINISHED) begin
			done_cnt_nxt = done_cnt_nxt + 16'h0001;
		end
		if (clamp_evt) begin
			clamp_cnt_nxt = clamp_cnt_nxt + 16'h0001;
		end
	end

	// state registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tri_sel_r   <= `CFG_RESET;
			prdata_r    <= 32'h0000_0000;
			done_cnt_r  <= 16'h0000;
			clamp_cnt_r <= 16'h0000;
			res_valid_r <= 1'b0;
			key_r       <= default_key;
			ptr_r       <= 8'h00;
			ftype_r     <= mac_layer_type;
			done_r      <= 1'b0;
			pp_valid_r  <= 1'b0;
			pp_red_r    <= 1'b0;
			pp_code_r   <= 5'h00;
			strip_r     <= 1'b0;
			strip_b_r   <= 6'h00;
			clamp_r     <= 1'b0;
		end else begin
			tri_sel_r   <= tri_sel_nxt;
			prdata_r    <= prdata_nxt;
			done_cnt_r  <= done_cnt_nxt;
			clamp_cnt_r <= clamp_cnt_nxt;
			res_valid_r <= res_valid_nxt;
			key_r       <= key_nxt;
			ptr_r       <= ptr_nxt;
			ftype_r     <= ftype_nxt;
			done_r      <= done_nxt;
			pp_valid_r  <= pp_valid_nxt;
			pp_red_r    <= pp_red_nxt;
			pp_code_r   <= pp_code_nxt;
			strip_r     <= strip_nxt;
			strip_b_r   <= strip_b_nxt;
			clamp_r     <= clamp_nxt;
		end
	end

	// outputs
	assign pready_o           = 1'b1;
	assign pslverr_o          = psel_i && penable_i && !mapped;
	assign prdata_o           = prdata_r;
	assign res_valid_o        = res_valid_r;
	assign next_key_o         = key_r;
	assign next_ptr_o         = ptr_r;
	assign next_frame_type_o  = ftype_r;
	assign lookups_disabled_o = done_r;
	assign pp_valid_o         = pp_valid_r;
	assign pp_reduced_o       = pp_red_r;
	assign pp_code_o          = pp_code_r;
	assign strip_o            = strip_r;
	assign strip_bytes_o      = strip_b_r;
	assign strip_clamped_o    = clamp_r;

endmodule : clm_action_pointer_ctrl

// File: tb/clm_action_sva.sv
// concurrent checks on the ports of the action pointer decoder
module clm_action_sva
	import clm_action_pkg::*;
(
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	input wire logic        act_valid_i,
	input wire logic        frame_start_i,
	input wire logic        reduced_layout_i,
	input wire logic        force_pipeline_point_enable_i,
	input wire logic [2:0]  reduced_pipeline_point_i,
	input wire logic [4:0]  pipeline_point_i,
	input wire logic [3:0]  next_lookup_key_select_i,
	input wire logic [1:0]  next_ptr_word4_advance_i,
	input wire logic [4:0]  next_ptr_word2_advance_i,
	input wire logic [1:0]  layer_skip_select_i,
	input wire frame_type_t frame_type_i,
	input wire logic [7:0]  frame_ptr_i,
	input wire logic        res_valid_o,
	input wire key_kind_t   next_key_o,
	input wire logic [7:0]  next_ptr_o,
	input wire frame_type_t next_frame_type_o,
	input wire logic        lookups_disabled_o,
	input wire logic        pp_valid_o,
	input wire logic        pp_reduced_o,
	input wire logic [4:0]  pp_code_o,
	input wire logic        strip_o,
	input wire logic [5:0]  strip_bytes_o,
	input wire logic        strip_clamped_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// taken unless finished; a frame start in the same cycle reopens
	wire taken = act_valid_i && (!lookups_disabled_o || frame_start_i);
	wire no_skip = layer_skip_select_i inside {2'h0, 2'h3};
	wire force_pp = taken && force_pipeline_point_enable_i;
	wire still = no_skip && (reduced_layout_i ? next_ptr_word4_advance_i == 2'h0
		: next_ptr_word2_advance_i == 5'h00);

	property p_answer;
		taken |=> res_valid_o;
	endproperty
	a_answer: assert property (p_answer) else $error("missing result");
	property p_drop;
		act_valid_i && lookups_disabled_o && !frame_start_i |=> !res_valid_o;
	endproperty
	a_drop: assert property (p_drop) else $error("late action taken");
	property p_finish;
		taken && next_lookup_key_select_i == 4'hf
			|=> lookups_disabled_o && next_key_o == lookups_finished;
	endproperty
	a_finish: assert property (p_finish) else $error("no finish");
	property p_default;
		taken && next_lookup_key_select_i == 4'h0 |=> next_key_o == default_key;
	endproperty
	a_default: assert property (p_default) else $error("key forced");
	property p_pp_red;
		force_pp && reduced_layout_i |=> pp_valid_o && pp_reduced_o
			&& pp_code_o == {2'h0, $past(reduced_pipeline_point_i)};
	endproperty
	a_pp_red: assert property (p_pp_red) else $error("reduced point");
	property p_pp_full;
		force_pp && !reduced_layout_i |=> pp_valid_o && !pp_reduced_o
			&& pp_code_o == $past(pipeline_point_i);
	endproperty
	a_pp_full: assert property (p_pp_full) else $error("pipe point");
	property p_w4;
		taken && reduced_layout_i && no_skip && frame_ptr_i < 8'hf0
			|=> next_ptr_o == $past(frame_ptr_i)
			+ {4'h0, $past(next_ptr_word4_advance_i), 2'h0};
	endproperty
	a_w4: assert property (p_w4) else $error("word4 advance");
	property p_w2;
		taken && !reduced_layout_i && no_skip && frame_ptr_i < 8'hc0
			|=> next_ptr_o == $past(frame_ptr_i)
			+ {2'h0, $past(next_ptr_word2_advance_i), 1'h0};
	endproperty
	a_w2: assert property (p_w2) else $error("word2 advance");
	property p_keep;
		taken && still && frame_type_i != raw_data_type
			|=> next_frame_type_o == $past(frame_type_i);
	endproperty
	a_keep: assert property (p_keep) else $error("type changed");
	property p_strip;
		res_valid_o && strip_o |-> strip_clamped_o == (next_ptr_o > 8'h2a)
			&& strip_bytes_o == (strip_clamped_o ? 6'h2a : next_ptr_o[5:0]);
	endproperty
	a_strip: assert property (p_strip) else $error("strip count");

	c_finish: cover property (taken && next_lookup_key_select_i == 4'hf);
	c_drop: cover property (act_valid_i && lookups_disabled_o && !frame_start_i);
	c_clamp: cover property (res_valid_o && strip_clamped_o);
endmodule : clm_action_sva

bind clm_action_pointer_ctrl clm_action_sva clm_action_sva_i (.*);

// File: tb/clm_far_side.sv
// model of the key generator and rewriter consuming decoded results
module clm_far_side (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        res_valid_i,
	input  wire logic        strip_i,
	input  wire logic [5:0]  strip_bytes_i,
	output logic      [15:0] rx_cnt_o,
	output logic      [5:0]  strip_max_o
);
	// results are taken only in their one valid cycle
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_cnt_o <= 16'h0000;
			strip_max_o <= 6'h00;
		end else if (res_valid_i) begin
			rx_cnt_o <= rx_cnt_o + 16'h0001;
			if (strip_i && strip_bytes_i > strip_max_o)
				strip_max_o <= strip_bytes_i;
		end
	end
endmodule : clm_far_side

// File: tb/clm_action_pointer_ctrl_tb_top.sv
// self-checking bench for the action pointer decoder
module clm_action_pointer_ctrl_tb_top
	import clm_action_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, r;
	logic [3:0] pstrb_i, next_lookup_key_select_i, ip_version_i, ipv4_ihl_i;
	logic frame_start_i, act_valid_i, reduced_layout_i, strip_to_pointer_i;
	logic force_pipeline_point_enable_i, res_valid_o, lookups_disabled_o;
	logic pp_valid_o, pp_reduced_o, strip_o, strip_clamped_o, e, fs, dis, mv;
	logic [1:0] lookup_idx_i, vlan_cnt_i, next_ptr_word4_advance_i;
	logic [1:0] layer_skip_select_i;
	logic [2:0] reduced_pipeline_point_i, cfg;
	logic [4:0] pipeline_point_i, next_ptr_word2_advance_i, pp_code_o;
	logic [4:0] ppc;
	logic ppv, ppr;
	logic [7:0] frame_ptr_i, next_ptr_o, np;
	logic [5:0] strip_bytes_o, strip_max;
	logic [15:0] rx_cnt;
	frame_type_t frame_type_i, layer_type_after_move_i, next_frame_type_o;
	key_kind_t next_key_o;
	int bad_count, checks_done, cycles, seed, sent, done_n, k, clamp_n;

	clm_action_pointer_ctrl clm_action_pointer_ctrl_i (.*);
	clm_far_side clm_far_side_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.res_valid_i(res_valid_o), .strip_i(strip_o),
		.strip_bytes_i(strip_bytes_o), .rx_cnt_o(rx_cnt),
		.strip_max_o(strip_max));

	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task final_report;
		$display("checks=%0d mismatches=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	// hang guard, far above the roughly 620 cycles the run needs
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			final_report();
		end
	end

	// apb transfer; psel stays up so the next setup may follow at once
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		@(posedge sys_clk_i);
		while (pready_o !== 1'b1) @(posedge sys_clk_i);
		r = prdata_o;
		e = pslverr_o;
	endtask : apb

	function int rnd(input int n);
		return {$random(seed)} % n;
	endfunction : rnd

	function key_kind_t exp_key(input logic [3:0] c, input logic v);
		if (c == 4'h5)
			return v ? triple_vlan_index_key : triple_vlan_key;
		if (c > 4'h5 && c < 4'ha)
			return key_kind_t'(c + 5'h01);
		return key_kind_t'({1'h0, c});
	endfunction : exp_key

	// layer skip first, then the word advance, saturating at the top
	function logic [7:0] exp_ptr(input int adv);
		int n, ip;
		ip = ip_version_i == 4'h4 ? ipv4_ihl_i * 4 : ip_version_i == 4'h6 ? 40 : 0;
		n = 0;
		if (frame_type_i == mac_layer_type && layer_skip_select_i != 2'h0)
			n = 12 + 4 * vlan_cnt_i + (layer_skip_select_i == 2'h2 ? ip : 0);
		if (frame_type_i == control_word_type && layer_skip_select_i == 2'h2)
			n = ip;
		n = frame_ptr_i + n + adv;
		return n > 255 ? 8'hff : n[7:0];
	endfunction : exp_ptr

	initial begin
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		{frame_start_i, act_valid_i, reduced_layout_i, strip_to_pointer_i} = '0;
		{force_pipeline_point_enable_i, lookup_idx_i, vlan_cnt_i} = '0;
		{next_lookup_key_select_i, ip_version_i, ipv4_ihl_i} = '0;
		{next_ptr_word4_advance_i, next_ptr_word2_advance_i} = '0;
		{layer_skip_select_i, reduced_pipeline_point_i, pipeline_point_i} = '0;
		frame_ptr_i = 8'h00;
		frame_type_i = mac_layer_type;
		layer_type_after_move_i = mac_layer_type;
		pstrb_i = 4'hf;
		seed = 50755;
		dis = 1'b0;
		{ppv, ppr, ppc} = 7'h00;
		rst_n_i = 1'b0;
		repeat (4) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(posedge sys_clk_i);
		apb(1'b0, 12'h000, 32'h0);
		chk(r, 32'h0);
		cfg = 3'($random(seed));
		apb(1'b1, 12'h000, {29'h0, cfg});
		apb(1'b0, 12'h000, 32'h0);
		chk(r, {29'h0, cfg});
		apb(1'b0, 12'h010, 32'h0);
		chk(r, 32'h0);
		chk(e, 1'b1);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		for (int i = 0; i < 300; i++) begin
			@(posedge sys_clk_i);
			fs = rnd(8) == 0;
			frame_start_i <= fs;
			lookup_idx_i <= 2'(rnd(3));
			frame_type_i <= frame_type_t'(rnd(4));
			frame_ptr_i <= i > 290 ? 8'hf8 : 8'(rnd(160));
			vlan_cnt_i <= 2'(rnd(4));
			ip_version_i <= rnd(2) ? 4'h4 : 4'(rnd(16));
			ipv4_ihl_i <= 4'(5 + rnd(11));
			reduced_layout_i <= 1'(rnd(2));
			force_pipeline_point_enable_i <= 1'(rnd(2));
			reduced_pipeline_point_i <= 3'(rnd(8));
			pipeline_point_i <= 5'(rnd(17));
			// code 10 is never programmed; it is folded onto the finish code
			k = rnd(15) + (rnd(9) == 0);
			next_lookup_key_select_i <= 4'(k == 10 ? 15 : k);
			next_ptr_word4_advance_i <= 2'(rnd(4));
			next_ptr_word2_advance_i <= 5'(rnd(32));
			layer_skip_select_i <= 2'(rnd(3));
			layer_type_after_move_i <= frame_type_t'(rnd(4));
			strip_to_pointer_i <= 1'(rnd(2));
			act_valid_i <= 1'b1;
			@(posedge sys_clk_i);
			act_valid_i <= 1'b0;
			frame_start_i <= 1'b0;
			@(negedge sys_clk_i);
			chk(res_valid_o, fs || !dis);
			// a frame start drops the forced point before the action applies
			if (fs)
				{ppv, ppr, ppc} = 7'h00;
			if (fs || !dis) begin
				sent++;
				np = exp_ptr(reduced_layout_i ? next_ptr_word4_advance_i * 4
					: next_ptr_word2_advance_i * 2);
				mv = np != frame_ptr_i;
				chk(next_key_o, exp_key(next_lookup_key_select_i,
					cfg[lookup_idx_i]));
				chk(next_ptr_o, np);
				chk(next_frame_type_o, (mv || (frame_type_i == raw_data_type
					&& next_lookup_key_select_i != 4'h0))
					? layer_type_after_move_i : frame_type_i);
				if (strip_to_pointer_i)
					chk(strip_bytes_o, np > 42 ? 42 : np);
				chk({strip_o, strip_clamped_o}, {strip_to_pointer_i,
					strip_to_pointer_i && np > 42});
				clamp_n += strip_to_pointer_i && np > 42;
				if (force_pipeline_point_enable_i) begin
					ppv = 1'b1;
					ppr = reduced_layout_i;
					ppc = reduced_layout_i ? {2'h0, reduced_pipeline_point_i}
						: pipeline_point_i;
				end
				dis = next_lookup_key_select_i == 4'hf;
				done_n += dis;
			end
			chk(lookups_disabled_o, dis);
			chk({pp_valid_o, pp_reduced_o, pp_code_o}, {ppv, ppr, ppc});
		end
		@(posedge sys_clk_i);
		apb(1'b0, 12'h008, 32'h0);
		chk(r, done_n);
		apb(1'b0, 12'h00c, 32'h0);
		chk(r, clamp_n);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		chk(rx_cnt, sent);
		chk(strip_max <= 6'h2a, 1'b1);
		final_report();
	end
endmodule : clm_action_pointer_ctrl_tb_top
